// >>> core/eip_core.sv
// extended interrupt enable and priority registers with request selection
// What this block does
// - comparator 0 rising or falling flag requests only while its enable is set.
// - counter array requests pass only while enable-one bit 4 is set.
// - adc window flag requests only while enable-one bit 2 is set.
// - port match requests pass only while enable-one bit 1 is set.
// - smbus requests pass only while enable-one bit 0 is set.
// - priority-low bits give level lsb per source; bit 7 is timer 3.
// - priority-low bit 6 is comparator 1; rest follow enable-one order.
// - priority-high bits give level msb with the same bit mapping.
// - timer 4 low or high overflow requests only while enable-two bit 4 set.
// - i2c slave requests pass only while enable-two bit 3 is set.
// - second uart requests pass only while enable-two bit 2 is set.
// - vbus and charger requests pass only while enable-two bit 1 set.
// - global enable clear blocks all; set lets each own enable decide.
`timescale 1ns/1ps
module eip_core (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic [7:0]        sfr_wdata,
  input  wire logic              sfr_rd,
  output logic [7:0]             sfr_rdata,
  input  wire logic              global_irq_enable,
  input  wire logic              comparator_rising_flag,
  input  wire logic              comparator_falling_flag,
  input  wire logic              comparator_one_pending,
  input  wire logic              counter_array_pending,
  input  wire logic              adc_window_flag,
  input  wire logic              adc_conversion_pending,
  input  wire logic              port_match_pending,
  input  wire logic              smbus_pending,
  input  wire logic              timer_three_pending,
  input  wire logic              usb_event_pending,
  input  wire logic              vbus_charger_pending,
  input  wire logic              second_uart_pending,
  input  wire logic              i2c_slave_pending,
  input  wire logic              timer_four_low_overflow,
  input  wire logic              timer_four_high_overflow,
  input  wire logic              core_in_handler,
  input  wire eip_pkg::eip_level_t core_active_level,
  output logic                   irq_request,
  output eip_pkg::eip_src_t      irq_source,
  output eip_pkg::eip_level_t    irq_level,
  output logic [7:0]             extended_irq_enable_one,
  output logic [7:0]             extended_irq_enable_two
);
  import eip_pkg::*;

  logic [7:0]  enable_one_reg;
  logic [7:0]  enable_two_reg;
  logic [7:0]  priority_low_reg;
  logic [7:0]  priority_high_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        request_reg;
  logic        request_next;
  eip_src_t    source_reg;
  eip_level_t  level_reg;

  wire hit_one  = (sfr_addr == ADDR_ENABLE_ONE);
  wire hit_two  = (sfr_addr == ADDR_ENABLE_TWO);
  wire hit_low  = (sfr_addr == ADDR_PRIORITY_LOW);
  wire hit_high = (sfr_addr == ADDR_PRIORITY_HIGH);

  // named enable bits
  wire smbus_irq_enable          = enable_one_reg[BIT_SMBUS];
  wire port_match_irq_enable     = enable_one_reg[BIT_PORT_MAT];
  wire adc_window_irq_enable     = enable_one_reg[BIT_ADC_WIN];
  wire adc_conversion_irq_enable = enable_one_reg[BIT_ADC_CONV];
  wire counter_array_irq_enable  = enable_one_reg[BIT_COUNTER];
  wire comparator_zero_irq_enable= enable_one_reg[BIT_CMP_ZERO];
  wire comparator_one_irq_enable = enable_one_reg[BIT_CMP_ONE];
  wire timer_three_irq_enable    = enable_one_reg[BIT_TIMER3];
  wire usb_event_irq_enable      = enable_two_reg[BIT_USB];
  wire vbus_charger_irq_enable   = enable_two_reg[BIT_VBUS];
  wire second_uart_irq_enable    = enable_two_reg[BIT_UART_TWO];
  wire i2c_slave_irq_enable      = enable_two_reg[BIT_I2C_SLAVE];
  wire timer_four_irq_enable     = enable_two_reg[BIT_TIMER4];

  // gated requests, indexed by source number
  wire [NSRC-1:0] gated;
  assign gated[SRC_SMBUS]     = smbus_pending & smbus_irq_enable;
  assign gated[SRC_PORT_MAT]  =
    port_match_pending & port_match_irq_enable;
  assign gated[SRC_ADC_WIN]   =
    adc_window_flag & adc_window_irq_enable;
  assign gated[SRC_ADC_CONV]  =
    adc_conversion_pending & adc_conversion_irq_enable;
  assign gated[SRC_COUNTER]   =
    counter_array_pending & counter_array_irq_enable;
  assign gated[SRC_CMP_ZERO]  =
    (comparator_rising_flag | comparator_falling_flag)
    & comparator_zero_irq_enable;
  assign gated[SRC_CMP_ONE]   =
    comparator_one_pending & comparator_one_irq_enable;
  assign gated[SRC_TIMER3]    =
    timer_three_pending & timer_three_irq_enable;
  assign gated[SRC_USB]       =
    usb_event_pending & usb_event_irq_enable;
  assign gated[SRC_VBUS]      =
    vbus_charger_pending & vbus_charger_irq_enable;
  assign gated[SRC_UART_TWO]  =
    second_uart_pending & second_uart_irq_enable;
  assign gated[SRC_I2C_SLAVE] =
    i2c_slave_pending & i2c_slave_irq_enable;
  assign gated[SRC_TIMER4]    =
    (timer_four_low_overflow | timer_four_high_overflow)
    & timer_four_irq_enable;

  // the global enable sits in front of every individual mask
  wire [NSRC-1:0] active = gated & {NSRC{global_irq_enable}};

  // two-bit levels for sources 0-7: msb from the high register, lsb from the low one; sources 8 up take LEVEL_DEFAULT
  wire [2*NSRC-1:0] levels;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lvl
      assign levels[2*g +: 2] =
        {priority_high_reg[g], priority_low_reg[g]};
    end
    for (g = 8; g < NSRC; g++) begin : g_dflt
      assign levels[2*g +: 2] = LEVEL_DEFAULT;
    end
  endgenerate

  logic       pick_found;
  eip_src_t   pick_source;
  eip_level_t pick_level;

  eip_pick u_pick (
    .active (active),
    .levels (levels),
    .found  (pick_found),
    .source (pick_source),
    .level  (pick_level)
  );

  // a running handler is only interrupted by a strictly higher level
  assign request_next = pick_found &&
    (!core_in_handler || pick_level > core_active_level);

  assign rdata_next =
    hit_one  ? enable_one_reg :
    hit_two  ? enable_two_reg :
    hit_low  ? priority_low_reg :
    hit_high ? priority_high_reg : RDATA_UNMAPPED;

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_one_reg    <= RST_ENABLE_ONE;
      enable_two_reg    <= RST_ENABLE_TWO;
      priority_low_reg  <= RST_PRIORITY_LOW;
      priority_high_reg <= RST_PRIORITY_HIGH;
    end else if (sfr_wr) begin
      if (hit_one)  enable_one_reg    <= sfr_wdata;
      // reserved bits never store, so they keep reading zero
      if (hit_two)  enable_two_reg    <= sfr_wdata & ENABLE_TWO_MASK;
      if (hit_low)  priority_low_reg  <= sfr_wdata;
      if (hit_high) priority_high_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg   <= RDATA_UNMAPPED;
      request_reg <= 1'b0;
      source_reg  <= SRC_SMBUS;
      level_reg   <= LEVEL_DEFAULT;
    end else begin
      if (sfr_rd) rdata_reg <= rdata_next;
      request_reg <= request_next;
      source_reg  <= pick_source;
      level_reg   <= pick_level;
    end
  end

  assign sfr_rdata               = rdata_reg;
  assign irq_request             = request_reg;
  assign irq_source              = source_reg;
  assign irq_level               = level_reg;
  assign extended_irq_enable_one = enable_one_reg;
  assign extended_irq_enable_two = enable_two_reg;

  a_cmp0_masked: assert property (@(posedge clk) disable iff (reset)
    irq_request && irq_source == SRC_CMP_ZERO |->
    $past(enable_one_reg[BIT_CMP_ZERO]) &&
    $past(comparator_rising_flag || comparator_falling_flag))
    else $error("comparator 0 request while masked or idle");
  a_counter_gate: assert property (@(posedge clk) disable iff (reset)
    irq_request && irq_source == SRC_COUNTER |->
    $past(enable_one_reg[BIT_COUNTER]))
    else $error("counter array request while masked");
  a_window_gate: assert property (@(posedge clk) disable iff (reset)
    irq_request && irq_source == SRC_ADC_WIN |->
    $past(enable_one_reg[BIT_ADC_WIN]) && $past(adc_window_flag))
    else $error("adc window request while masked");
  a_match_gate: assert property (@(posedge clk) disable iff (reset)
    irq_request && irq_source == SRC_PORT_MAT |->
    $past(enable_one_reg[BIT_PORT_MAT]))
    else $error("port match request while masked");
  a_smbus_alone: assert property (@(posedge clk) disable iff (reset)
    global_irq_enable && !core_in_handler && smbus_pending &&
    smbus_irq_enable && active == 13'h0001 |=>
    irq_request && irq_source == SRC_SMBUS)
    else $error("lone smbus request not presented");
  a_level_bits: assert property (@(posedge clk) disable iff (reset)
    irq_request && irq_source == SRC_TIMER3 |->
    irq_level == $past({priority_high_reg[7], priority_low_reg[7]}))
    else $error("timer 3 level not taken from priority bits");
  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    sfr_wr && hit_two |=> enable_two_reg[7:5] == 3'h0 &&
    enable_two_reg[4:0] == $past(sfr_wdata[4:0]))
    else $error("enable-two write stored wrongly");
  a_timer4_gate: assert property (@(posedge clk) disable iff (reset)
    irq_request && irq_source == SRC_TIMER4 |->
    $past(enable_two_reg[BIT_TIMER4]))
    else $error("timer 4 request while masked");
  a_global_off: assert property (@(posedge clk) disable iff (reset)
    !global_irq_enable |=> !irq_request)
    else $error("request with global enable clear");
  a_preempt_higher: assert property (@(posedge clk) disable iff (reset)
    irq_request && $past(core_in_handler) |->
    irq_level > $past(core_active_level))
    else $error("preempted by equal or lower level");
  a_usb_gate: assert property (@(posedge clk) disable iff (reset)
    irq_request && irq_source == SRC_USB |->
    $past(enable_two_reg[BIT_USB]))
    else $error("usb request while masked");
endmodule // eip_core

// >>> core/eip_pick.sv
// picks the pending enabled source with the highest level
`timescale 1ns/1ps
module eip_pick (
  input  wire logic [eip_pkg::NSRC-1:0]   active,
  input  wire logic [2*eip_pkg::NSRC-1:0] levels,
  output logic                            found,
  output eip_pkg::eip_src_t               source,
  output eip_pkg::eip_level_t             level
);
  import eip_pkg::*;

  // scan from the last source down so the lowest number wins a tie
  always_comb begin
    found  = 1'b0;
    source = SRC_SMBUS;
    level  = LEVEL_DEFAULT;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (active[i] && (!found || levels[2*i +: 2] >= level)) begin
        found  = 1'b1;
        source = eip_src_t'(i);
        level  = levels[2*i +: 2];
      end
    end
  end
endmodule // eip_pick

// >>> shared/eip_pkg.sv
// constants for the extended interrupt enable and priority block
package eip_pkg;
  localparam int SRC_W = 4;
  localparam int NSRC  = 13;
  typedef logic [SRC_W-1:0] eip_src_t;
  typedef logic [1:0]       eip_level_t;

  // register addresses on the special function register port
  localparam logic [7:0] ADDR_ENABLE_ONE     = 8'hE6;
  localparam logic [7:0] ADDR_ENABLE_TWO     = 8'hCE;
  localparam logic [7:0] ADDR_PRIORITY_LOW   = 8'hF3;
  localparam logic [7:0] ADDR_PRIORITY_HIGH  = 8'hF5;

  // reset values
  localparam logic [7:0] RST_ENABLE_ONE      = 8'h00;
  localparam logic [7:0] RST_ENABLE_TWO      = 8'h00;
  localparam logic [7:0] RST_PRIORITY_LOW    = 8'h00;
  localparam logic [7:0] RST_PRIORITY_HIGH   = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED      = 8'h00;

  // writable bits of the second enable register, bits 7:5 reserved
  localparam logic [7:0] ENABLE_TWO_MASK     = 8'h1F;

  // bit positions of the first enable / priority registers
  localparam int BIT_SMBUS     = 0;
  localparam int BIT_PORT_MAT  = 1;
  localparam int BIT_ADC_WIN   = 2;
  localparam int BIT_ADC_CONV  = 3;
  localparam int BIT_COUNTER   = 4;
  localparam int BIT_CMP_ZERO  = 5;
  localparam int BIT_CMP_ONE   = 6;
  localparam int BIT_TIMER3    = 7;
  // bit positions of the second enable register
  localparam int BIT_USB       = 0;
  localparam int BIT_VBUS      = 1;
  localparam int BIT_UART_TWO  = 2;
  localparam int BIT_I2C_SLAVE = 3;
  localparam int BIT_TIMER4    = 4;

  // source numbers, also the fixed tie-break order (lower wins)
  localparam eip_src_t SRC_SMBUS     = 4'h0;
  localparam eip_src_t SRC_PORT_MAT  = 4'h1;
  localparam eip_src_t SRC_ADC_WIN   = 4'h2;
  localparam eip_src_t SRC_ADC_CONV  = 4'h3;
  localparam eip_src_t SRC_COUNTER   = 4'h4;
  localparam eip_src_t SRC_CMP_ZERO  = 4'h5;
  localparam eip_src_t SRC_CMP_ONE   = 4'h6;
  localparam eip_src_t SRC_TIMER3    = 4'h7;
  localparam eip_src_t SRC_USB       = 4'h8;
  localparam eip_src_t SRC_VBUS      = 4'h9;
  localparam eip_src_t SRC_UART_TWO  = 4'hA;
  localparam eip_src_t SRC_I2C_SLAVE = 4'hB;
  localparam eip_src_t SRC_TIMER4    = 4'hC;

  // level given to sources whose priority bits live outside this block
  localparam eip_level_t LEVEL_DEFAULT = 2'h0;
endpackage

// >>> testbench/eip_core_test.sv
// self-checking bench for the extended interrupt enable and priority block
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module eip_core_test;
  import eip_pkg::*;
  logic        clk, reset, sfr_wr, sfr_rd, glb, have;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, en1, en2;
  logic [7:0]  m_en1, m_en2, m_pl, m_ph;
  logic [17:0] word;
  wire  [14:0] flags;
  wire         hnd;
  wire  [1:0]  alv;
  logic        irq_request, e_req;
  eip_level_t  irq_level, e_lvl;
  eip_src_t    irq_source, e_src;
  integer      seed = 1871;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [7:0]  addrs [5];

  eip_src_model eip_src_model_inst (.word(word), .flags(flags),
    .in_handler(hnd), .active_level(alv));
  eip_core eip_core_inst (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .global_irq_enable(glb),
    .comparator_rising_flag(flags[5]), .comparator_falling_flag(flags[6]),
    .comparator_one_pending(flags[7]), .counter_array_pending(flags[4]),
    .adc_window_flag(flags[2]), .adc_conversion_pending(flags[3]),
    .port_match_pending(flags[1]), .smbus_pending(flags[0]),
    .timer_three_pending(flags[8]), .usb_event_pending(flags[9]),
    .vbus_charger_pending(flags[10]), .second_uart_pending(flags[11]),
    .i2c_slave_pending(flags[12]), .timer_four_low_overflow(flags[13]),
    .timer_four_high_overflow(flags[14]), .core_in_handler(hnd),
    .core_active_level(alv), .irq_request(irq_request),
    .irq_source(irq_source), .irq_level(irq_level),
    .extended_irq_enable_one(en1), .extended_irq_enable_two(en2));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] shadow(input logic [7:0] a);
    case (a)
      ADDR_ENABLE_ONE:    return m_en1;
      ADDR_ENABLE_TWO:    return m_en2;
      ADDR_PRIORITY_LOW:  return m_pl;
      ADDR_PRIORITY_HIGH: return m_ph;
      default:            return RDATA_UNMAPPED;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    case (a)
      ADDR_ENABLE_ONE:    m_en1 = d;
      ADDR_ENABLE_TWO:    m_en2 = d & ENABLE_TWO_MASK;
      ADDR_PRIORITY_LOW:  m_pl = d;
      ADDR_PRIORITY_HIGH: m_ph = d;
      default:            ;
    endcase
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CHK("read data", shadow(a), sfr_rdata)
  endtask

  // reference built from the enable and priority shadows with integers
  task automatic predict();
    logic [12:0] act;
    logic [12:0] en;
    int          best;
    int          lv;
    act = {word[14] | word[13], word[12:7], word[6] | word[5], word[4:0]};
    en = {m_en2[4:0], m_en1};
    best = -1;
    e_src = '0;
    e_lvl = '0;
    for (int i = 0; i < NSRC; i++) begin
      lv = (i < 8) ? 2 * int'(m_ph[i]) + int'(m_pl[i]) : 0;
      // strict compare keeps the lowest source number on a tie
      if (act[i] && en[i] && lv > best) begin
        best = lv;
        e_src = eip_src_t'(i);
        e_lvl = eip_level_t'(lv);
      end
    end
    e_req = glb && best >= 0 && (!word[15] || best > int'(word[17:16]));
  endtask

  task automatic check();
    `CHK("request", e_req, irq_request)
    if (e_req) begin
      `CHK("source", e_src, irq_source)
      `CHK("level", e_lvl, irq_level)
    end
    `CHK("enable one copy", m_en1, en1)
    `CHK("enable two copy", m_en2, en2)
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #(5 * 4000);
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    addrs = '{ADDR_ENABLE_ONE, ADDR_ENABLE_TWO, ADDR_PRIORITY_LOW,
              ADDR_PRIORITY_HIGH, 8'h55};
    reset = 1'b1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    glb = 1'b0;
    word = '0;
    have = 1'b0;
    m_en1 = RST_ENABLE_ONE;
    m_en2 = RST_ENABLE_TWO;
    m_pl = RST_PRIORITY_LOW;
    m_ph = RST_PRIORITY_HIGH;
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    foreach (addrs[i]) rd(addrs[i]);
    `CHK("request after reset", 1'b0, irq_request)
    $display("test reset values done");
    // random data on purpose hits the reserved bits and the unmapped slot
    foreach (addrs[i]) begin
      wr(addrs[i], 8'($random(seed)));
      rd(addrs[i]);
    end
    wr(ADDR_ENABLE_TWO, 8'hFF);
    rd(ADDR_ENABLE_TWO);
    $display("test register access done");
    repeat (24) begin
      for (int i = 0; i < 4; i++) wr(addrs[i], 8'($random(seed)));
      wr(ADDR_ENABLE_TWO, 8'($random(seed)) & 8'h1F);
      have = 1'b0;
      repeat (30) begin
        @(negedge clk);
        if (have)
          check();
        word = 18'($random(seed));
        glb = ($random(seed) & 3) != 0;
        predict();
        have = 1'b1;
      end
    end
    $display("test request selection done");
    stop_test();
  end
endmodule // eip_core_test

// >>> testbench/eip_src_model.sv
// peripheral pending flags and core handler state facing the block
`timescale 1ns/1ps
module eip_src_model (
  input  wire logic [17:0] word,
  output logic [14:0]      flags,
  output logic             in_handler,
  output logic [1:0]       active_level
);
  // flags are levels owned by the peripherals; nothing here clears them,
  // so a masked flag stays pending and must stay invisible to the core
  assign flags        = word[14:0];
  assign in_handler   = word[15];
  assign active_level = word[17:16];
endmodule // eip_src_model
